// File: include/uaf_pkg.sv
// Constants, field positions and state type for the address-filter block
package uaf_pkg;
  // Register word indices on the Avalon-MM port
  localparam logic [1:0] ADDR_DATA   = 2'h0;
  localparam logic [1:0] ADDR_CSA    = 2'h1;
  localparam logic [1:0] ADDR_CSB    = 2'h2;
  localparam logic [1:0] ADDR_SHARED = 2'h3;
  // serial_ctrl_status_a bit positions
  localparam int CSA_RXDONE = 7;
  localparam int CSA_TXDONE = 6;
  localparam int CSA_UDRE = 5;
  localparam int CSA_FE   = 4;
  localparam int CSA_DOR  = 3;
  localparam int CSA_PE   = 2;
  localparam int CSA_U2X  = 1;
  localparam int CSA_FILT = 0;
  // Control B bit positions
  localparam int CSB_RXEN = 4;
  localparam int CSB_TXEN = 3;
  localparam int CSB_SZ2  = 2;
  localparam int CSB_RX9  = 1;
  localparam int CSB_TX9  = 0;
  // Frame-control bit positions
  localparam int CSC_SEL  = 7;
  localparam int CSC_SYNC = 6;
  localparam int CSC_PM1  = 5;
  localparam int CSC_PM0  = 4;
  localparam int CSC_TWO  = 3;
  localparam int CSC_SZ1  = 2;
  localparam int CSC_SZ0  = 1;
  localparam int CSC_POL  = 0;
  // Reset values
  localparam logic [7:0] CSB_RST   = 8'h00;
  localparam logic [7:0] CSC_RST   = 8'h86;
  localparam logic [6:0] BAUDH_RST = 7'h00;
  // Character size code for nine data bits
  localparam logic [2:0] SIZE_NINE = 3'h7;

  typedef struct packed {
    logic       waitReq;
    logic [7:0] rdData;
    logic       prevShared;
    logic [7:0] rxData;
    logic       rxNinth;
    logic       rxDone;
    logic       txDone;
    logic       fe;
    logic       dor;
    logic       pe;
    logic       u2x;
    logic       filt;
    logic [7:0] csb;
    logic [6:0] csc;
    logic [6:0] baudHigh;
  } uaf_state_t;
endpackage : uaf_pkg

// File: include/uaf_frame_if.sv
// Received-frame carrier between the register core and the frame filter
`timescale 1ns/100ps
interface uaf_frame_if;
  logic       valid;
  logic [8:0] data;
  logic       stopBit;
  logic       nineBit;
  logic       filterEn;
  logic       accept;
  logic       isAddr;
  modport src (output valid, data, stopBit, nineBit, filterEn, input accept, isAddr);
  modport flt (input valid, data, stopBit, nineBit, filterEn, output accept, isAddr);
endinterface : uaf_frame_if

// File: logic/uaf_frame_filter.sv
// Frame-type decode and address filter for received frames
`timescale 1ns/100ps
module uaf_frame_filter (
  uaf_frame_if.flt frm
);
  import uaf_pkg::*;

  // Ninth data bit or first stop bit carries the type
  assign frm.isAddr = frm.nineBit ? frm.data[8] : frm.stopBit;
  // Data frames dropped only while filtering
  assign frm.accept = frm.valid & (~frm.filterEn | frm.isAddr);
endmodule : uaf_frame_filter

// File: logic/uaf_top.sv
// Register core with address filtering and shared-location access
// Notes on behaviour
// - With filter bit set, non-address frames are dropped, never buffered.
// - For five to eight data bits, first stop bit gives frame type.
// - For nine data bits, ninth bit (also stored) gives frame type.
// - Type one means address frame; type zero means data frame.
// - Transmitter ignores the filter bit; only receiver filters.
// - Accepted address frame is buffered and sets receive-complete normally.
// - With filter bit clear, every data frame is accepted normally.
// - Transmitter and receiver share one character-size setting.
// - Shared-location write: top bit zero writes baud high, one frame-control.
// - Shared read returns baud high; right after such read, frame-control.
// - Writing one clears transmit-complete; interrupt acknowledge clears it too.
// - Frame-control read returns its select bit as one.
// - Filter enable is bit 0 of control-and-status register A.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module uaf_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Receiver frame handoff
  input  wire logic        rxFrameValid,
  input  wire logic [8:0]  rxFrameData,
  input  wire logic        rxStopBit,
  input  wire logic        rxParityErr,
  // Transmitter status
  input  wire logic        txShiftDone,
  input  wire logic        txBufEmpty,
  input  wire logic        txDoneAck,
  // Shared configuration
  output logic [2:0]       charSizeSel,
  output logic             twoStopSel,
  output logic [1:0]       parityMode,
  output logic             syncMode,
  output logic             clkPolarity,
  output logic             doubleSpeed,
  output logic             addrFilterEn,
  output logic             rxEnable,
  output logic             txEnable,
  output logic             txNinthBit,
  output logic             txCompleteFlag,
  output logic [6:0]       baudDivHigh
);
  import uaf_pkg::*;

  uaf_state_t st;
  uaf_state_t next_st;
  uaf_frame_if frm ();

  logic       req;
  logic       done;
  logic       wrByte;
  logic       dataRead;
  logic [7:0] readMux;
  logic [2:0] sizeCode;

  uaf_frame_filter u_filter (
    .frm (frm.flt)
  );

  // One size code for both directions
  assign sizeCode     = {st.csb[CSB_SZ2], st.csc[CSC_SZ1], st.csc[CSC_SZ0]};
  assign frm.valid    = rxFrameValid & st.csb[CSB_RXEN];
  assign frm.data     = rxFrameData;
  assign frm.stopBit  = rxStopBit;
  assign frm.nineBit  = (sizeCode == SIZE_NINE);
  assign frm.filterEn = st.filt;

  assign req      = avs_read | avs_write;
  assign done     = req & ~st.waitReq;
  assign wrByte   = done & avs_write & avs_byteenable[0];
  assign dataRead = done & avs_read & (avs_address == ADDR_DATA);

  always_comb begin
    unique case (avs_address)
      ADDR_DATA:
        readMux = st.rxData;
      ADDR_CSA:
        readMux = {st.rxDone, st.txDone, txBufEmpty, st.fe, st.dor, st.pe, st.u2x, st.filt};
      ADDR_CSB:
        readMux = {st.csb[7:CSB_SZ2], st.rxNinth, st.csb[CSB_TX9]};
      ADDR_SHARED: begin
        // Second of a back-to-back pair sees frame control
        if (st.prevShared) begin
          readMux = {1'b1, st.csc};
        end else begin
          readMux = {1'b0, st.baudHigh};
        end
      end
    endcase
  end

  always_comb begin
    next_st = st;
    // Only a shared read completing this edge arms the pair
    next_st.prevShared = done & avs_read & (avs_address == ADDR_SHARED);

    // Two-cycle handshake: answer captured, then released
    if (req && st.waitReq) begin
      next_st.waitReq = 1'b0;
      next_st.rdData  = readMux;
    end else begin
      next_st.waitReq = 1'b1;
    end

    // Reading the data port empties the one-deep buffer
    if (dataRead) begin
      next_st.rxDone = 1'b0;
      next_st.fe  = 1'b0;
      next_st.dor = 1'b0;
      next_st.pe  = 1'b0;
    end

    if (wrByte) begin
      unique case (avs_address)
        ADDR_DATA: begin
        end
        ADDR_CSA: begin
          // Write-one-to-clear; error flags are read only
          if (avs_writedata[CSA_TXDONE]) begin
            next_st.txDone = 1'b0;
          end
          next_st.u2x  = avs_writedata[CSA_U2X];
          next_st.filt = avs_writedata[CSA_FILT];
        end
        ADDR_CSB: begin
          next_st.csb = avs_writedata[7:0];
        end
        ADDR_SHARED: begin
          if (avs_writedata[CSC_SEL]) begin
            next_st.csc = avs_writedata[CSC_SEL-1:0];
          end else begin
            next_st.baudHigh = avs_writedata[CSC_SEL-1:0];
          end
        end
      endcase
    end

    // Hardware clears first, sets last, so a coincident event wins
    if (txDoneAck) begin
      next_st.txDone = 1'b0;
    end
    if (txShiftDone) begin
      next_st.txDone = 1'b1;
    end

    // Disabled receiver flushes the buffer and its flags
    if (!st.csb[CSB_RXEN]) begin
      next_st.rxDone = 1'b0;
      next_st.fe  = 1'b0;
      next_st.dor = 1'b0;
      next_st.pe  = 1'b0;
    end

    // Dropped frames touch nothing at all
    if (frm.accept) begin
      if (next_st.rxDone) begin
        // Buffer still full: keep old data, flag the loss
        next_st.dor = 1'b1;
      end else begin
        next_st.rxData  = rxFrameData[7:0];
        next_st.rxNinth = rxFrameData[8];
        next_st.rxDone  = 1'b1;
        next_st.fe      = ~rxStopBit;
        next_st.pe      = rxParityErr & st.csc[CSC_PM1];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st            <= '0;
      st.waitReq    <= 1'b1;
      st.csb        <= CSB_RST;
      st.csc        <= CSC_RST[CSC_SEL-1:0];
      st.baudHigh   <= BAUDH_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state; filter bit feeds no transmit output
  assign avs_readdata    = {24'h000000, st.rdData};
  assign avs_waitrequest = st.waitReq;
  assign charSizeSel     = sizeCode;
  assign twoStopSel      = st.csc[CSC_TWO];
  assign parityMode      = {st.csc[CSC_PM1], st.csc[CSC_PM0]};
  assign syncMode        = st.csc[CSC_SYNC];
  assign clkPolarity     = st.csc[CSC_POL];
  assign doubleSpeed     = st.u2x;
  assign addrFilterEn    = st.filt;
  assign rxEnable        = st.csb[CSB_RXEN];
  assign txEnable        = st.csb[CSB_TXEN];
  assign txNinthBit      = st.csb[CSB_TX9];
  assign txCompleteFlag  = st.txDone;
  assign baudDivHigh     = st.baudHigh;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_drop_data;
    (frm.valid && st.filt && !frm.isAddr && !dataRead)
      |=> $stable({st.rxData, st.rxDone, st.fe, st.dor, st.pe});
  endproperty
  a_drop_data: assert property (p_drop_data) else $error("filtered frame changed buffer");

  property p_type_nine;
    (frm.nineBit && frm.valid) |-> (frm.isAddr == rxFrameData[8]);
  endproperty
  a_type_nine: assert property (p_type_nine) else $error("nine-bit type not from bit 8");

  property p_type_stop;
    (!frm.nineBit && frm.valid) |-> (frm.isAddr == rxStopBit);
  endproperty
  a_type_stop: assert property (p_type_stop) else $error("short-frame type not from stop bit");

  property p_addr_taken;
    (frm.valid && st.filt && frm.isAddr && !st.rxDone)
      |=> (st.rxDone && st.rxData == $past(rxFrameData[7:0]));
  endproperty
  a_addr_taken: assert property (p_addr_taken) else $error("address frame not buffered");

  property p_nofilt_taken;
    (frm.valid && !st.filt && !st.rxDone) |=> st.rxDone;
  endproperty
  a_nofilt_taken: assert property (p_nofilt_taken) else $error("unfiltered frame not taken");

  property p_shared_write;
    (wrByte && avs_address == ADDR_SHARED && avs_writedata[CSC_SEL])
      |=> (st.csc == $past(avs_writedata[CSC_SEL-1:0])) && $stable(st.baudHigh);
  endproperty
  a_shared_write: assert property (p_shared_write) else $error("select bit ignored on write");

  property p_read_first;
    (avs_read && st.waitReq && avs_address == ADDR_SHARED && !st.prevShared)
      |=> (avs_readdata[7:0] == {1'b0, $past(st.baudHigh)}) && !avs_waitrequest;
  endproperty
  a_read_first: assert property (p_read_first) else $error("lone read not baud high");

  property p_read_second;
    (avs_read && st.waitReq && avs_address == ADDR_SHARED && st.prevShared)
      |=> (avs_readdata[7:0] == {1'b1, $past(st.csc)});
  endproperty
  a_read_second: assert property (p_read_second) else $error("paired read not frame control");

  property p_done_clear;
    (wrByte && avs_address == ADDR_CSA && avs_writedata[CSA_TXDONE] && !txShiftDone)
      |=> !txCompleteFlag;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("transmit-complete not cleared");

  property p_filt_bit;
    (wrByte && avs_address == ADDR_CSA)
      |=> (addrFilterEn == $past(avs_writedata[CSA_FILT])) && $stable(txNinthBit);
  endproperty
  a_filt_bit: assert property (p_filt_bit) else $error("filter bit write wrong");
endmodule : uaf_top

// File: tb/uaf_frame_src.sv
// Far-side serial master model handing finished frames to the receiver
`timescale 1ns/100ps
module uaf_frame_src (
  // Clock
  input  wire logic mclk,
  // Frame handoff
  output logic       rxFrameValid,
  output logic [8:0] rxFrameData,
  output logic       rxStopBit,
  output logic       rxParityErr
);
  initial begin
    rxFrameValid = 1'b0;
    rxFrameData  = 9'h000;
    rxStopBit    = 1'b1;
    rxParityErr  = 1'b1;
  end

  // Type rides in the ninth bit, or in the first of two stop bits
  task automatic send(input logic [8:0] d, input logic stopBit);
    @(posedge mclk);
    rxFrameValid <= 1'b1;
    rxFrameData  <= d;
    rxStopBit    <= stopBit;
    rxParityErr  <= 1'b0;
    @(posedge mclk);
    rxFrameValid <= 1'b0;
    // Released lines show the inverse so stale values never match
    rxFrameData  <= ~d;
    rxStopBit    <= ~stopBit;
    rxParityErr  <= 1'b1;
  endtask : send
endmodule : uaf_frame_src

// File: tb/uaf_top_tb.sv
// Self-checking bench for frame filtering and shared-location access
`timescale 1ns/100ps
module uaf_top_tb;
  import uaf_pkg::*;
  logic        mclk, rst, avs_read, avs_write, avs_waitrequest;
  logic [1:0]  avs_address, parityMode;
  logic [31:0] avs_writedata, avs_readdata, rd0, rd1;
  logic [3:0]  avs_byteenable;
  logic        rxFrameValid, rxStopBit, rxParityErr, txShiftDone, txBufEmpty, txDoneAck;
  logic [8:0]  rxFrameData;
  logic [2:0]  charSizeSel;
  logic        twoStopSel, syncMode, clkPolarity, doubleSpeed, addrFilterEn;
  logic        rxEnable, txEnable, txNinthBit, txCompleteFlag;
  logic [6:0]  baudDivHigh;
  int          errCount, checked;

  uaf_top uut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxFrameValid(rxFrameValid),
    .rxFrameData(rxFrameData), .rxStopBit(rxStopBit), .rxParityErr(rxParityErr),
    .txShiftDone(txShiftDone), .txBufEmpty(txBufEmpty), .txDoneAck(txDoneAck),
    .charSizeSel(charSizeSel), .twoStopSel(twoStopSel), .parityMode(parityMode), .syncMode(syncMode),
    .clkPolarity(clkPolarity), .doubleSpeed(doubleSpeed), .addrFilterEn(addrFilterEn),
    .rxEnable(rxEnable), .txEnable(txEnable), .txNinthBit(txNinthBit),
    .txCompleteFlag(txCompleteFlag), .baudDivHigh(baudDivHigh));

  uaf_frame_src src (.mclk(mclk), .rxFrameValid(rxFrameValid), .rxFrameData(rxFrameData),
    .rxStopBit(rxStopBit), .rxParityErr(rxParityErr));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic stopTest;
    if (errCount == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stopTest

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait for the answer edge; data taken at that edge
  task automatic waitAns(output logic [31:0] rd);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      errCount++;
      $display("BAD %0t no bus answer", $time);
    end
    rd = avs_readdata;
  endtask : waitAns

  task automatic avWrite(input logic [1:0] a, input logic [7:0] d);
    logic [31:0] unused;
    avs_write     <= 1'b1;
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    waitAns(unused);
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : avWrite

  // n=2 keeps read high across two answers, a back-to-back pair
  task automatic avRead(input logic [1:0] a, input int n, output logic [31:0] r0, output logic [31:0] r1);
    avs_read    <= 1'b1;
    avs_address <= a;
    waitAns(r0);
    r1 = 32'h0;
    if (n > 1) waitAns(r1);
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask : avRead

  task automatic rdChk(input logic [1:0] a, input logic [7:0] exp);
    avRead(a, 1, rd0, rd1);
    chk(rd0, {24'h0, exp});
  endtask : rdChk

  task automatic pulse(input logic ack);
    if (ack) txDoneAck <= 1'b1;
    else txShiftDone <= 1'b1;
    @(posedge mclk);
    txDoneAck   <= 1'b0;
    txShiftDone <= 1'b0;
    @(posedge mclk);
  endtask : pulse

  initial begin
    repeat (20000) @(posedge mclk);
    errCount++;
    stopTest();
  end

  initial begin
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    {txShiftDone, txDoneAck} = 2'h0;
    txBufEmpty = 1'b1;
    errCount   = 0;
    checked    = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdChk(ADDR_CSB, 8'h00);
    avRead(ADDR_SHARED, 2, rd0, rd1);
    chk(rd0, 32'h00);
    chk(rd1, 32'h86);
    avWrite(ADDR_SHARED, 8'h02);
    avWrite(ADDR_SHARED, 8'h8e);
    avRead(ADDR_SHARED, 2, rd0, rd1);
    chk(rd0, 32'h02);
    chk(rd1, 32'h8e);
    // Baud high 2, two stop bits, no parity, asynchronous, polarity low
    chk({20'h0, baudDivHigh, twoStopSel, parityMode, syncMode, clkPolarity}, 32'h050);
    rdChk(ADDR_SHARED, 8'h02);
    rdChk(ADDR_SHARED, 8'h02);
    // Nine-bit characters, receiver on, filter on
    avWrite(ADDR_CSB, 8'h14);
    chk({29'h0, charSizeSel}, 32'h7);
    chk({29'h0, rxEnable, txEnable, txNinthBit}, 32'h4);
    avWrite(ADDR_CSA, 8'h01);
    chk({31'h0, addrFilterEn}, 32'h1);
    src.send(9'h033, 1'b1);
    rdChk(ADDR_CSA, 8'h21);
    src.send(9'h044, 1'b0);
    rdChk(ADDR_CSA, 8'h21);
    src.send(9'h1a5, 1'b1);
    rdChk(ADDR_CSA, 8'ha1);
    rdChk(ADDR_CSB, 8'h16);
    rdChk(ADDR_DATA, 8'ha5);
    rdChk(ADDR_CSA, 8'h21);
    avWrite(ADDR_CSA, 8'h00);
    src.send(9'h05a, 1'b1);
    rdChk(ADDR_DATA, 8'h5a);
    rdChk(ADDR_CSA, 8'h20);
    avWrite(ADDR_CSA, 8'h01);
    // Eight-bit characters: stop bit carries the type
    avWrite(ADDR_CSB, 8'h10);
    chk({29'h0, charSizeSel}, 32'h3);
    src.send(9'h1c3, 1'b0);
    rdChk(ADDR_CSA, 8'h21);
    src.send(9'h03c, 1'b1);
    rdChk(ADDR_CSA, 8'ha1);
    // Second address while full: overrun flagged, first byte kept
    src.send(9'h0ff, 1'b1);
    rdChk(ADDR_CSA, 8'ha9);
    rdChk(ADDR_DATA, 8'h3c);
    rdChk(ADDR_CSA, 8'h21);
    // Transmit status is untouched by the filter
    pulse(1'b0);
    chk({31'h0, txCompleteFlag}, 32'h1);
    rdChk(ADDR_CSA, 8'h61);
    avWrite(ADDR_CSA, 8'h41);
    chk({30'h0, txCompleteFlag, addrFilterEn}, 32'h1);
    pulse(1'b0);
    pulse(1'b1);
    chk({31'h0, txCompleteFlag}, 32'h0);
    avWrite(ADDR_CSB, 8'h19);
    chk({29'h0, rxEnable, txEnable, txNinthBit}, 32'h7);
    avWrite(ADDR_CSA, 8'h03);
    // Buffer-empty status is read live
    txBufEmpty <= 1'b0;
    rdChk(ADDR_CSA, 8'h03);
    chk({30'h0, doubleSpeed, addrFilterEn}, 32'h3);
    stopTest();
  end
endmodule : uaf_top_tb
